// file: core/oag_address_gen.sv
// Operand address generator: mode decode, address sums, multiply
`timescale 1ns/10ps
`default_nettype none
`include "oag_regs.svh"
module oag_address_gen
   import oag_pkg::*;
#(
   // Byte and address widths; the carrier structs fix both
   parameter int DATA_W = 8,
   parameter int ADDR_W = 16
)
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Request from the decode stage
   input wire logic req_valid_i,
   input wire oag_req_type req_i,
   input wire logic [7:0] acc_i,
   input wire logic [7:0] idx_i,
   input wire logic [7:0] bit_byte_i,
   // Result towards the memory bus
   output logic res_valid_o,
   output oag_res_type res_o,
   // Multiply result, product split over both registers
   output logic mul_valid_o,
   output logic [7:0] mul_acc_o,
   output logic [7:0] mul_idx_o,
   // Bit tested by a bit branch
   output logic carry_valid_o,
   output logic carry_o
);
   oag_res_type next_res;
   logic [7:0] prod_high;
   logic [7:0] prod_low;
   logic tested_bit;
   logic [15:0] branch_pc;
   logic mul_ok;
   logic branch_ok;
   logic combo_bad;

   // The structs and the multiplier are built for these widths only
   if (DATA_W != 8) begin : g_data_w_check
      $error("oag_address_gen: DATA_W must be 8");
   end
   if (ADDR_W != 16) begin : g_addr_w_check
      $error("oag_address_gen: ADDR_W must be 16");
   end

   oag_multiply u_mul (
      .acc_i(acc_i),
      .idx_i(idx_i),
      .high_o(prod_high),
      .low_o(prod_low)
   );

   // Wrapping 16-bit add; the carry out is dropped on purpose
   function automatic logic [15:0] add16(input logic [15:0] a,
                                         input logic [15:0] b);
      add16 = a + b;
   endfunction : add16

   // Branch offsets are two's complement bytes
   function automatic logic [15:0] sext8(input logic [7:0] b);
      sext8 = {{8{b[7]}}, b};
   endfunction : sext8

   function automatic logic [15:0] rel_target(input logic [15:0] pc,
                                              input logic [7:0] off);
      rel_target = add16(pc, sext8(off));
   endfunction : rel_target

   // Multiply has no operand bytes, so only the inherent form exists
   function automatic logic mul_legal(input oag_req_type r);
      mul_legal = r.op == oag_op_unsigned_multiply
                  && r.mode == OAG_INHERENT;
   endfunction : mul_legal

   // Bit branches test a byte in the low page, so direct form only
   function automatic logic branch_legal(input oag_req_type r);
      branch_legal = r.op == OAG_OP_BIT_BRANCH && r.mode == OAG_DIRECT;
   endfunction : branch_legal

   function automatic logic bit_op(input oag_op_type op);
      bit_op = op == OAG_OP_BIT_WRITE || op == OAG_OP_BIT_BRANCH;
   endfunction : bit_op

   // An op paired with a mode that has no encoding for it
   function automatic logic combo_illegal(input oag_req_type r);
      combo_illegal = (bit_op(r.op) && r.mode != OAG_DIRECT)
                      || (r.op == oag_op_unsigned_multiply
                          && r.mode != OAG_INHERENT);
   endfunction : combo_illegal

   // Bit picked from the byte read at the direct address
   assign tested_bit = bit_byte_i[req_i.bit_sel];
   assign mul_ok = mul_legal(req_i);
   assign branch_ok = branch_legal(req_i);
   assign combo_bad = combo_illegal(req_i);

   // Branch resolution for plain and bit-test branches
   always_comb begin
      branch_pc = req_i.next_pc;
      if (req_i.mode == OAG_RELATIVE && req_i.taken) begin
         branch_pc = rel_target(req_i.next_pc, req_i.byte1);
      end
      if (branch_ok && tested_bit == req_i.bit_one) begin
         branch_pc = rel_target(req_i.next_pc, req_i.byte2);
      end
   end

   // Mode decode: length, address and data for each mode
   always_comb begin
      next_res = '0;
      next_res.pc = branch_pc;
      case (req_i.mode)
         OAG_INHERENT: begin
            next_res.length = `OAG_LEN_ONE;
         end
         OAG_IMMEDIATE: begin
            next_res.length = `OAG_LEN_TWO;
            next_res.data = req_i.byte1;
            next_res.data_valid = 1'b1;
         end
         OAG_DIRECT: begin
            next_res.length = `OAG_LEN_TWO;
            next_res.addr = {`OAG_ZERO_HIGH, req_i.byte1};
            next_res.addr_valid = 1'b1;
            if (req_i.op == OAG_OP_BIT_BRANCH) begin
               next_res.length = `OAG_LEN_THREE;
            end
         end
         OAG_EXTENDED: begin
            next_res.length = `OAG_LEN_THREE;
            next_res.addr = {req_i.byte1, req_i.byte2};
            next_res.addr_valid = 1'b1;
         end
         OAG_INDEXED_NONE: begin
            next_res.length = `OAG_LEN_ONE;
            next_res.addr = {`OAG_ZERO_HIGH, idx_i};
            next_res.addr_valid = 1'b1;
         end
         OAG_INDEXED_BYTE: begin
            next_res.length = `OAG_LEN_TWO;
            next_res.addr = add16({8'h00, idx_i}, {8'h00, req_i.byte1});
            next_res.addr_valid = 1'b1;
         end
         OAG_INDEXED_WORD: begin
            next_res.length = `OAG_LEN_THREE;
            next_res.addr = add16({8'h00, idx_i},
                                  {req_i.byte1, req_i.byte2});
            next_res.addr_valid = 1'b1;
         end
         OAG_RELATIVE: begin
            next_res.length = `OAG_LEN_TWO;
         end
         default: begin
            next_res.illegal = 1'b1;
         end
      endcase
      // A bad op/mode pairing yields no address and no data
      if (combo_bad) begin
         next_res.illegal = 1'b1;
         next_res.addr_valid = 1'b0;
         next_res.data_valid = 1'b0;
      end
   end

   // One answer per request, exactly one cycle later
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         res_valid_o <= 1'b0;
      end else begin
         res_valid_o <= req_valid_i;
      end
   end

   // Result fields hold between requests
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         res_o <= '0;
      end else if (req_valid_i) begin
         res_o <= next_res;
      end
   end

   // Valid only for the legal inherent multiply
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mul_valid_o <= 1'b0;
      end else begin
         mul_valid_o <= req_valid_i && mul_ok;
      end
   end

   // A refused multiply leaves both registers untouched
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mul_acc_o <= `OAG_RESET_BYTE;
         mul_idx_o <= `OAG_RESET_BYTE;
      end else if (req_valid_i && mul_ok) begin
         mul_idx_o <= prod_high;
         mul_acc_o <= prod_low;
      end
   end

   // Valid only for a legal bit branch
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         carry_valid_o <= 1'b0;
      end else begin
         carry_valid_o <= req_valid_i && branch_ok;
      end
   end

   // A refused bit branch must not disturb the carry
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         carry_o <= 1'b0;
      end else if (req_valid_i && branch_ok) begin
         carry_o <= tested_bit;
      end
   end
endmodule : oag_address_gen
`default_nettype wire

// file: core/oag_regs.svh
// Constants for the operand address generator
// How it works
// - Eight addressing modes, no more
// - Inherent: opcode only, no address
// - Immediate: second byte is the data
// - Direct: zero high byte, low byte operand
// - Extended: high byte then low byte
// - Indexed no offset: index as low byte
// - Indexed 8-bit: index plus byte, unsigned
// - Indexed 16-bit: index plus high-low offset
// - Multiply: high to index, low to accumulator
// - Relative: taken adds signed offset to next
// - Bit branch: direct, offset, bit to carry
// - Bit set/clear only with direct mode
`ifndef OAG_REGS_SVH
`define OAG_REGS_SVH
`define OAG_ZERO_HIGH 8'h00
`define OAG_RESET_ADDR 16'h0000
`define OAG_RESET_BYTE 8'h00
`define OAG_LEN_ONE 2'h1
`define OAG_LEN_TWO 2'h2
`define OAG_LEN_THREE 2'h3
`endif

// file: core/oag_pkg.sv
// Types for the operand address generator
package oag_pkg;
   typedef enum logic [2:0] {
      OAG_INHERENT,
      OAG_IMMEDIATE,
      OAG_DIRECT,
      OAG_EXTENDED,
      OAG_INDEXED_NONE,
      OAG_INDEXED_BYTE,
      OAG_INDEXED_WORD,
      OAG_RELATIVE
   } oag_mode_type;

   typedef enum logic [1:0] {
      OAG_OP_NORMAL,
      oag_op_unsigned_multiply,
      OAG_OP_BIT_WRITE,
      OAG_OP_BIT_BRANCH
   } oag_op_type;

   typedef struct packed {
      oag_mode_type mode;
      oag_op_type op;
      logic [7:0] byte1;
      logic [7:0] byte2;
      logic [15:0] next_pc;
      logic taken;
      logic bit_one;
      logic [2:0] bit_sel;
   } oag_req_type;

   typedef struct packed {
      logic [15:0] addr;
      logic addr_valid;
      logic [7:0] data;
      logic data_valid;
      logic [1:0] length;
      logic [15:0] pc;
      logic illegal;
   } oag_res_type;
endpackage : oag_pkg

// file: core/oag_multiply.sv
// Unsigned 8x8 multiplier
`timescale 1ns/10ps
`default_nettype none
module oag_multiply (
   // Operands
   input wire logic [7:0] acc_i,
   input wire logic [7:0] idx_i,
   // Product halves
   output logic [7:0] high_o,
   output logic [7:0] low_o
);
   logic [15:0] product;
   assign product = 16'(acc_i) * 16'(idx_i);
   assign high_o = product[15:8];
   assign low_o = product[7:0];
endmodule : oag_multiply
`default_nettype wire

// file: sim/oag_address_gen_sva.sv
// Assertions on the operand address generator ports
`timescale 1ns/10ps
`default_nettype none
module oag_address_gen_sva
   import oag_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Watched ports
   input wire logic req_valid_i,
   input wire oag_req_type req_i,
   input wire logic [7:0] idx_i,
   input wire logic [7:0] acc_i,
   input wire logic [7:0] bit_byte_i,
   input wire logic res_valid_o,
   input wire oag_res_type res_o,
   input wire logic mul_valid_o,
   input wire logic [7:0] mul_acc_o,
   input wire logic [7:0] mul_idx_o,
   input wire logic carry_valid_o,
   input wire logic carry_o
);
   oag_req_type q;
   logic [7:0] qx;
   logic [7:0] qa;
   logic [7:0] qb;
   logic v;
   logic mr;
   logic bb;
   logic bo;
   oag_mode_type m;
   assign v = req_valid_i && req_i.op == OAG_OP_NORMAL;
   assign m = req_i.mode;
   assign mr = req_valid_i && req_i.op == oag_op_unsigned_multiply;
   assign bb = req_valid_i && req_i.op == OAG_OP_BIT_BRANCH;
   assign bo = bb || (req_valid_i && req_i.op == OAG_OP_BIT_WRITE);
   always_ff @(posedge clk_sys_i) begin
      q <= req_i;
      qx <= idx_i;
      qa <= acc_i;
      qb <= bit_byte_i;
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   one_answer_a: assert property (res_valid_o == $past(req_valid_i))
      else $error("answer pulse wrong");
   inh_len_a: assert property (v && m == OAG_INHERENT |=>
      res_o.length == 2'h1 && !res_o.addr_valid) else $error("inherent");
   imm_data_a: assert property (v && m == OAG_IMMEDIATE |=>
      res_o.data == q.byte1 && res_o.data_valid) else $error("immediate");
   dir_addr_a: assert property (v && m == OAG_DIRECT |=>
      res_o.addr == {8'h00, q.byte1}) else $error("direct");
   idx_none_a: assert property (v && m == OAG_INDEXED_NONE |=>
      res_o.addr == {8'h00, qx}) else $error("indexed none");
   idx_byte_a: assert property (v && m == OAG_INDEXED_BYTE |=>
      res_o.addr == {8'h00, qx} + q.byte1) else $error("indexed byte");
   idx_word_a: assert property (v && m == OAG_INDEXED_WORD |=>
      res_o.addr == qx + {q.byte1, q.byte2}) else $error("indexed word");
   rel_pc_a: assert property (v && m == OAG_RELATIVE |=>
      res_o.pc == 16'(q.next_pc + (q.taken ? {{8{q.byte1[7]}}, q.byte1}
         : 16'h0000))) else $error("relative");
   ext_addr_a: assert property (v && m == OAG_EXTENDED |=>
      res_o.addr == {q.byte1, q.byte2} && res_o.length == 2'h3
      && res_o.addr_valid) else $error("extended");
   mul_prod_a: assert property (mr && m == OAG_INHERENT |=>
      mul_valid_o && {mul_idx_o, mul_acc_o} == 16'(qa) * 16'(qx))
      else $error("multiply");
   mul_mode_a: assert property (mr && m != OAG_INHERENT |=>
      res_o.illegal && !mul_valid_o && $stable({mul_idx_o, mul_acc_o}))
      else $error("multiply mode");
   bit_carry_a: assert property (bb && m == OAG_DIRECT |=>
      carry_valid_o && carry_o == qb[q.bit_sel] && res_o.length == 2'h3
      && res_o.pc == 16'(q.next_pc + (qb[q.bit_sel] == q.bit_one
         ? {{8{q.byte2[7]}}, q.byte2} : 16'h0000)))
      else $error("bit branch");
   bit_mode_a: assert property (bo && m != OAG_DIRECT |=>
      res_o.illegal && !res_o.addr_valid && !carry_valid_o)
      else $error("bit op mode");
   cover property (mul_valid_o);
   cover property (carry_valid_o);
   cover property (res_valid_o && res_o.illegal);
endmodule : oag_address_gen_sva
`default_nettype wire

// file: sim/oag_fetch_model.sv
// Decode-stage model that hands requests to the generator
`timescale 1ns/10ps
`default_nettype none
module oag_fetch_model
   import oag_pkg::*;
(
   // Clock
   input wire logic clk_sys_i,
   // Request towards the generator
   output logic req_valid_o,
   output oag_req_type req_o,
   output logic [7:0] acc_o,
   output logic [7:0] idx_o,
   output logic [7:0] bit_byte_o
);
   initial begin
      req_valid_o = 1'b0;
      {req_o, acc_o, idx_o, bit_byte_o} = '0;
   end
   task send(input oag_req_type r, input logic [7:0] a, x, b);
      @(posedge clk_sys_i);
      #1;
      req_valid_o = 1'b1;
      {req_o, acc_o, idx_o, bit_byte_o} = {r, a, x, b};
      @(posedge clk_sys_i);
      #1;
      req_valid_o = 1'b0;
      // Inverted so a stale operand can never look right
      {req_o, acc_o, idx_o, bit_byte_o} = ~{r, a, x, b};
   endtask : send
endmodule : oag_fetch_model
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the operand address generator
`timescale 1ns/10ps
`default_nettype none
module testbench
   import oag_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic req_valid_i, res_valid_o, mul_valid_o, carry_valid_o, carry_o;
   oag_req_type req_i;
   oag_res_type res_o;
   logic [7:0] acc_i, idx_i, bit_byte_i, mul_acc_o, mul_idx_o;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   always #5 clk_sys_i = ~clk_sys_i;
   oag_fetch_model u_oag_fetch_model (.clk_sys_i, .req_valid_o(req_valid_i),
      .req_o(req_i), .acc_o(acc_i), .idx_o(idx_i), .bit_byte_o(bit_byte_i));
   oag_address_gen u_oag_address_gen (.clk_sys_i, .resetn_i, .req_valid_i,
      .req_i, .acc_i, .idx_i, .bit_byte_i, .res_valid_o, .res_o, .mul_valid_o,
      .mul_acc_o, .mul_idx_o, .carry_valid_o, .carry_o);
   task chk(input logic [15:0] s, e);
      n_checks++;
      if (s !== e) begin
         fail_count++;
         $display("Error %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // Bit 3 of the tested byte is set; odd second byte means taken
   task go(oag_mode_type m, oag_op_type o, logic [7:0] b1, b2, a, x);
      u_oag_fetch_model.send({m, o, b1, b2, 16'h0100, b2[0], 1'b1, 3'h3},
         a, x, 8'h08);
   endtask : go
   task t_modes;
      for (int i = 0; i < 8; i++) begin
         go(oag_mode_type'(i), OAG_OP_NORMAL, 8'h12, 8'h34, 8'h05, 8'h20);
         chk(res_valid_o, 1'b1);
      end
      go(OAG_EXTENDED, OAG_OP_NORMAL, 8'h12, 8'h34, 8'h00, 8'h00);
      chk(res_o.addr, 16'h1234);
      chk(res_o.length, 2'h3);
   endtask : t_modes
   task t_index;
      go(OAG_INDEXED_WORD, OAG_OP_NORMAL, 8'hff, 8'hf0, 8'h00, 8'h20);
      chk(res_o.addr, 16'h0010);
      go(OAG_INDEXED_BYTE, OAG_OP_NORMAL, 8'hff, 8'h00, 8'h00, 8'hff);
      chk(res_o.addr, 16'h01fe);
   endtask : t_index
   task t_mul;
      go(OAG_INHERENT, oag_op_unsigned_multiply, 8'h00, 8'h00, 8'hff, 8'hfd);
      chk({mul_idx_o, mul_acc_o}, 16'hfc03);
      chk(mul_valid_o, 1'b1);
      // A multiply outside inherent form is refused and leaves the product registers unchanged
      go(OAG_DIRECT, oag_op_unsigned_multiply, 8'h00, 8'h00, 8'h02, 8'h03);
      chk({mul_idx_o, mul_acc_o}, 16'hfc03);
      chk({mul_valid_o, res_o.illegal, res_o.addr_valid}, 3'h2);
   endtask : t_mul
   task t_branch;
      go(OAG_RELATIVE, OAG_OP_NORMAL, 8'h80, 8'h01, 8'h00, 8'h00);
      chk(res_o.pc, 16'h0080);
      go(OAG_DIRECT, OAG_OP_BIT_BRANCH, 8'h40, 8'hfe, 8'h00, 8'h00);
      chk(res_o.pc, 16'h00fe);
      chk(carry_o, 1'b1);
      chk(carry_valid_o, 1'b1);
      // Tested bit clear, branch on zero: taken, carry gets the zero
      u_oag_fetch_model.send({OAG_DIRECT, OAG_OP_BIT_BRANCH, 8'h40, 8'hfe,
         16'h0100, 1'b0, 1'b0, 3'h3}, 8'h00, 8'h00, 8'h00);
      chk(res_o.pc, 16'h00fe);
      chk(carry_o, 1'b0);
      // Tested bit clear, branch on one: falls through
      u_oag_fetch_model.send({OAG_DIRECT, OAG_OP_BIT_BRANCH, 8'h40, 8'hfe,
         16'h0100, 1'b0, 1'b1, 3'h3}, 8'h00, 8'h00, 8'h00);
      chk(res_o.pc, 16'h0100);
      go(OAG_EXTENDED, OAG_OP_BIT_WRITE, 8'h40, 8'h00, 8'h00, 8'h00);
      chk(res_o.illegal, 1'b1);
   endtask : t_branch
   task end_sim;
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   initial begin
      repeat (6) @(posedge clk_sys_i);
      #1 resetn_i = 1'b1;
      t_modes;
      t_index;
      t_mul;
      t_branch;
      end_sim;
   end
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc > 200) begin
         fail_count++;
         end_sim;
      end
   end
endmodule : testbench
bind oag_address_gen oag_address_gen_sva u_sva (.clk_sys_i, .resetn_i,
   .req_valid_i, .req_i, .idx_i, .acc_i, .bit_byte_i, .res_valid_o, .res_o,
   .mul_valid_o, .mul_acc_o, .mul_idx_o, .carry_valid_o, .carry_o);
`default_nettype wire
